// ===== nic_pkg.sv
/*
 * Shared constants and carrier types for the nested priority interrupt controller.
 * Assumes one core clock, a synchronous active-low reset and a CPU core that
 * stalls while the controller runs an entry sequence.
 */
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package nic_pkg;
    localparam int NUM_VEC = 14;
    localparam int NUM_GRP = 4;
    localparam int PINS_PER_GRP = 4;
    localparam int NUM_PINS = 17;
    localparam int TLI_PIN = 16;
    localparam int EXT_FIRST = 2;
    localparam int EXT_LAST = 5;
    localparam int PUSH_LAST = 4;
    localparam int CC_HI_POS = 5;
    localparam int CC_LO_POS = 3;
    localparam logic [1:0] LVL0 = 2'b10;
    localparam logic [1:0] LVL1 = 2'b01;
    localparam logic [1:0] LVL2 = 2'b00;
    localparam logic [1:0] LVL3 = 2'b11;
    localparam logic [1:0] VPR_RO_FIELD = 2'b11;
    localparam logic [1:0] CC_TOP_BITS = 2'b11;
    localparam logic [15:0] ADDR_RESET = 16'hFFFE;
    localparam logic [15:0] ADDR_TRAP = 16'hFFFC;
    localparam logic [15:0] ADDR_VEC0 = 16'hFFFA;
    localparam logic [1:0] KIND_MASK = 2'h0;
    localparam logic [1:0] KIND_TLI = 2'h1;
    localparam logic [1:0] KIND_TRAP = 2'h2;
    localparam logic [1:0] KIND_RESET = 2'h3;

    typedef enum logic [2:0] {NIC_RESETVEC, NIC_RUN, NIC_PUSH, NIC_LOADPC, NIC_FETCH} nic_state_t;

    typedef struct packed {
        logic instrEnd;
        logic trapExec;
        logic iretExec;
        logic rimExec;
        logic simExec;
        logic haltExec;
        logic wfiExec;
    } nic_cpu_evt_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] x;
        logic [7:0] a;
        logic [7:0] cc;
    } nic_cpu_regs_t;

    typedef struct packed {
        logic pushStrobe;
        logic [7:0] pushData;
        logic pcLoad;
        logic [15:0] pcValue;
        logic fetchStart;
        logic busy;
    } nic_entry_t;

    typedef struct packed {
        logic write;
        logic [1:0] index;
        logic [7:0] data;
    } nic_vpr_acc_t;

    typedef struct packed {
        logic pending;
    } nic_latch_t;

    // rank 0 is the main level, rank 3 masks everything maskable
    function automatic logic [1:0] nic_rank(input logic [1:0] lv);
        logic [1:0] r;
        r = 2'h3;
        case (lv)
            LVL0: r = 2'h0;
            LVL1: r = 2'h1;
            LVL2: r = 2'h2;
            default: r = 2'h3;
        endcase
        return r;
    endfunction
endpackage

// ===== nic_req_latch.sv
/*
 * One pending-request latch per maskable vector.
 * Assumes set and clear come from logic on the core clock.
 */
`timescale 1ns/1ps
module nic_req_latch (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // request control
    input wire logic setReq,
    input wire logic clrReq,
    output logic pending
);
    nic_pkg::nic_latch_t st;
    nic_pkg::nic_latch_t next_st;

    // set beats clear so an event landing on the clear cycle survives
    always_comb begin
        next_st = st;
        if (clrReq) begin
            next_st.pending = 1'b0;
        end
        if (setReq) begin
            next_st.pending = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    assign pending = st.pending;

    latch_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        clkEn && pending && !clrReq |=> pending)
        else $error("pending request lost without a clear");
endmodule

// ===== nic_ctrl.sv
/*
 * Nested priority interrupt controller: request latching, arbitration,
 * entry sequencing (stack, vector, fetch), level tracking and halt/wait wake.
 * Assumes the CPU stalls while entry.busy is high, presents its registers on
 * cpuRegs, and on an interrupt return presents the popped condition code.
 */
`timescale 1ns/1ps
module nic_ctrl (
    // clock, reset, freeze
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // cpu core
    input wire nic_pkg::nic_cpu_evt_t cpuEvt,
    input wire nic_pkg::nic_cpu_regs_t cpuRegs,
    output nic_pkg::nic_entry_t entry,
    output logic [7:0] condCode,
    output logic haltMode,
    output logic waitMode,
    // vector priority registers
    input wire nic_pkg::nic_vpr_acc_t vprAcc,
    output logic [7:0] vprRdData,
    // top-level and external edge inputs
    input wire logic tliPin,
    input wire logic tliRise,
    input wire logic [15:0] extPin,
    input wire logic [15:0] extPinSelect,
    input wire logic [3:0] extSenseRise,
    // peripheral requests, vectors 1..13
    input wire logic [13:1] periphFlag,
    input wire logic [13:1] periphEnable,
    input wire logic [13:1] flagClear,
    input wire logic [13:1] haltWakeMask
);
    //--------------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------------
    typedef struct packed {
        nic_pkg::nic_state_t state;
        logic [2:0] pushCnt;
        logic [1:0] cur;
        logic [13:0][1:0] vpr;
        logic trapPend;
        logic tliPend;
        logic trapActive;
        logic halted;
        logic waiting;
        logic [3:0] selVec;
        logic [1:0] selKind;
        logic [1:0] selPrio;
        logic [15:0] selAddr;
        logic [13:1] ack;
        logic [16:0] s1;
        logic [16:0] s2;
        logic [16:0] s3;
        logic [16:0] stable;
        nic_pkg::nic_entry_t out;
        logic [7:0] ccOut;
        logic [7:0] rdData;
    } nic_ctrl_t;

    nic_ctrl_t st;
    nic_ctrl_t next_st;

    logic [16:0] edgeHit;
    logic [3:0] grpEdge;
    logic [13:1] reqSet;
    logic [13:1] pend;
    logic [13:1] cand;
    logic found;
    logic [3:0] best;
    logic [1:0] bestRank;
    logic boundary;
    logic instrBlock;
    logic trapNow;
    logic tliOk;

    //--------------------------------------------------------------------------
    // edge detection and request latches
    //--------------------------------------------------------------------------
    // an edge counts once the second and third stages agree on a new value
    always_comb begin
        // the top-level pin is handled apart so no group index runs past the sense bits
        for (int i = 0; i < nic_pkg::TLI_PIN; i++) begin
            edgeHit[i] = (st.s2[i] == st.s3[i]) && (st.s3[i] != st.stable[i]) &&
                (st.s3[i] == extSenseRise[i / nic_pkg::PINS_PER_GRP]);
        end
        edgeHit[nic_pkg::TLI_PIN] = (st.s2[nic_pkg::TLI_PIN] == st.s3[nic_pkg::TLI_PIN]) &&
            (st.s3[nic_pkg::TLI_PIN] != st.stable[nic_pkg::TLI_PIN]) &&
            (st.s3[nic_pkg::TLI_PIN] == tliRise);
        for (int g = 0; g < nic_pkg::NUM_GRP; g++) begin
            grpEdge[g] = |(edgeHit[g * nic_pkg::PINS_PER_GRP +: nic_pkg::PINS_PER_GRP] &
                extPinSelect[g * nic_pkg::PINS_PER_GRP +: nic_pkg::PINS_PER_GRP]);
        end
        for (int v = 1; v < nic_pkg::NUM_VEC; v++) begin
            if (v >= nic_pkg::EXT_FIRST && v <= nic_pkg::EXT_LAST) begin
                reqSet[v] = grpEdge[v - nic_pkg::EXT_FIRST];
            end else begin
                reqSet[v] = periphFlag[v] && periphEnable[v];
            end
        end
    end

    // edge sources clear on entry; every source clears on its flag clear sequence
    genvar gv;
    generate
        for (gv = 1; gv < nic_pkg::NUM_VEC; gv++) begin : g_latch
            nic_req_latch u_latch (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .clkEn(clkEn),
                .setReq(reqSet[gv]),
                .clrReq(flagClear[gv] || st.ack[gv]),
                .pending(pend[gv])
            );
        end
    endgenerate

    //--------------------------------------------------------------------------
    // arbitration
    //--------------------------------------------------------------------------
    // descending scan with >= lets the lower vector number win a tie
    always_comb begin
        found = 1'b0;
        best = 4'h0;
        bestRank = 2'h0;
        for (int v = nic_pkg::NUM_VEC - 1; v >= 1; v--) begin
            cand[v] = pend[v] && (!st.halted || haltWakeMask[v]);
            if (cand[v] && nic_pkg::nic_rank(st.vpr[v]) > nic_pkg::nic_rank(st.cur) &&
                (!found || nic_pkg::nic_rank(st.vpr[v]) >= bestRank)) begin
                found = 1'b1;
                best = 4'(v);
                bestRank = nic_pkg::nic_rank(st.vpr[v]);
            end
        end
    end

    assign boundary = cpuEvt.instrEnd || st.halted || st.waiting;
    assign instrBlock = cpuEvt.iretExec || cpuEvt.rimExec || cpuEvt.simExec ||
        cpuEvt.haltExec || cpuEvt.wfiExec;
    assign trapNow = st.trapPend || cpuEvt.trapExec;
    // the top-level input may cut into a trap handler even at level 3
    assign tliOk = st.tliPend && (st.cur != nic_pkg::LVL3 || st.trapActive);

    //--------------------------------------------------------------------------
    // next state
    //--------------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.s1 = {tliPin, extPin};
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < nic_pkg::NUM_PINS; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.stable[i] = st.s3[i];
            end
        end
        next_st.ack = '0;
        next_st.out.pushStrobe = 1'b0;
        next_st.out.pcLoad = 1'b0;
        next_st.out.fetchStart = 1'b0;
        if (vprAcc.write) begin
            for (int k = 0; k < 4; k++) begin
                if (4 * int'(vprAcc.index) + k < nic_pkg::NUM_VEC &&
                    vprAcc.data[2 * k +: 2] != nic_pkg::LVL0) begin
                    next_st.vpr[4 * int'(vprAcc.index) + k] = vprAcc.data[2 * k +: 2];
                end
            end
        end
        for (int k = 0; k < 4; k++) begin
            if (4 * int'(vprAcc.index) + k < nic_pkg::NUM_VEC) begin
                next_st.rdData[2 * k +: 2] = st.vpr[4 * int'(vprAcc.index) + k];
            end else begin
                next_st.rdData[2 * k +: 2] = nic_pkg::VPR_RO_FIELD;
            end
        end
        case (st.state)
            nic_pkg::NIC_RESETVEC: begin
                next_st.state = nic_pkg::NIC_LOADPC;
            end
            nic_pkg::NIC_RUN: begin
                if (cpuEvt.trapExec) begin
                    next_st.trapPend = 1'b1;
                end
                if (boundary && !instrBlock && (trapNow || tliOk || found)) begin
                    next_st.state = nic_pkg::NIC_PUSH;
                    next_st.pushCnt = 3'h0;
                    next_st.halted = 1'b0;
                    next_st.waiting = 1'b0;
                    if (trapNow) begin
                        next_st.trapPend = 1'b0;
                        next_st.trapActive = 1'b1;
                        next_st.selKind = nic_pkg::KIND_TRAP;
                        next_st.selAddr = nic_pkg::ADDR_TRAP;
                        next_st.selPrio = nic_pkg::LVL3;
                    end else if (tliOk) begin
                        next_st.tliPend = 1'b0;
                        // relies on the handler never trapping
                        next_st.trapActive = 1'b0;
                        next_st.selKind = nic_pkg::KIND_TLI;
                        next_st.selVec = 4'h0;
                        next_st.selAddr = nic_pkg::ADDR_VEC0;
                        next_st.selPrio = nic_pkg::LVL3;
                    end else begin
                        next_st.ack[best] = 1'b1;
                        next_st.selKind = nic_pkg::KIND_MASK;
                        next_st.selVec = best;
                        next_st.selAddr = nic_pkg::ADDR_VEC0 - {11'h000, best, 1'b0};
                        next_st.selPrio = st.vpr[best];
                    end
                end else if (cpuEvt.iretExec) begin
                    next_st.cur = {cpuRegs.cc[nic_pkg::CC_HI_POS],
                        cpuRegs.cc[nic_pkg::CC_LO_POS]};
                    next_st.trapActive = 1'b0;
                end else if (cpuEvt.rimExec) begin
                    next_st.cur = nic_pkg::LVL0;
                end else if (cpuEvt.simExec) begin
                    next_st.cur = nic_pkg::LVL3;
                end else if (cpuEvt.haltExec) begin
                    next_st.cur = nic_pkg::LVL0;
                    next_st.halted = 1'b1;
                end else if (cpuEvt.wfiExec) begin
                    next_st.cur = nic_pkg::LVL0;
                    next_st.waiting = 1'b1;
                end
            end
            nic_pkg::NIC_PUSH: begin
                next_st.out.pushStrobe = 1'b1;
                case (st.pushCnt)
                    3'h0: next_st.out.pushData = cpuRegs.pc[7:0];
                    3'h1: next_st.out.pushData = cpuRegs.pc[15:8];
                    3'h2: next_st.out.pushData = cpuRegs.x;
                    3'h3: next_st.out.pushData = cpuRegs.a;
                    default: next_st.out.pushData = st.ccOut;
                endcase
                next_st.pushCnt = st.pushCnt + 3'h1;
                if (st.pushCnt == 3'(nic_pkg::PUSH_LAST)) begin
                    next_st.state = nic_pkg::NIC_LOADPC;
                end
            end
            nic_pkg::NIC_LOADPC: begin
                next_st.out.pcLoad = 1'b1;
                next_st.out.pcValue = st.selAddr;
                next_st.cur = st.selPrio;
                next_st.state = nic_pkg::NIC_FETCH;
            end
            default: begin
                next_st.out.fetchStart = 1'b1;
                next_st.state = nic_pkg::NIC_RUN;
            end
        endcase
        // a new edge on the clear cycle is kept
        if (edgeHit[nic_pkg::TLI_PIN]) begin
            next_st.tliPend = 1'b1;
        end
        next_st.out.busy = (next_st.state != nic_pkg::NIC_RUN);
        next_st.ccOut = {nic_pkg::CC_TOP_BITS, next_st.cur[1], cpuRegs.cc[4],
            next_st.cur[0], cpuRegs.cc[2:0]};
    end

    //--------------------------------------------------------------------------
    // registers
    //--------------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st <= '0;
            st.state <= nic_pkg::NIC_RESETVEC;
            st.cur <= nic_pkg::LVL3;
            st.vpr <= '1;
            st.selKind <= nic_pkg::KIND_RESET;
            st.selAddr <= nic_pkg::ADDR_RESET;
            st.selPrio <= nic_pkg::LVL3;
            st.out.busy <= 1'b1;
            st.ccOut <= {nic_pkg::CC_TOP_BITS, nic_pkg::LVL3[1], 1'b0, nic_pkg::LVL3[0], 3'h0};
        end else if (clkEn) begin
            st <= next_st;
        end
    end

    assign entry = st.out;
    assign condCode = st.ccOut;
    assign haltMode = st.halted;
    assign waitMode = st.waiting;
    assign vprRdData = st.rdData;

    //--------------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n || !clkEn);

    push_burst_a: assert property ($rose(entry.pushStrobe) |->
        entry.pushStrobe [*5] ##1 !entry.pushStrobe)
        else $error("stacking is not five bytes");
    push_then_vec_a: assert property ($fell(entry.pushStrobe) |->
        entry.pcLoad ##1 entry.fetchStart && !entry.busy)
        else $error("vector load does not follow stacking");
    reset_vec_a: assert property (entry.pcLoad && st.selKind == nic_pkg::KIND_RESET |->
        entry.pcValue == nic_pkg::ADDR_RESET && st.cur == nic_pkg::LVL3)
        else $error("reset entry wrong");
    nmi_level_a: assert property (entry.pcLoad && st.selKind != nic_pkg::KIND_MASK |->
        st.cur == nic_pkg::LVL3)
        else $error("non-maskable entry not at level 3");
    mask_level_a: assert property (entry.pcLoad && st.selKind == nic_pkg::KIND_MASK |->
        st.cur == st.vpr[st.selVec] && entry.pcValue[0] == 1'b0)
        else $error("level not loaded from vector priority");
    entry_boundary_a: assert property ($rose(entry.busy) |->
        $past(cpuEvt.instrEnd || st.halted || st.waiting))
        else $error("entry began mid-instruction");
    level_mask_a: assert property (st.state == nic_pkg::NIC_RUN &&
        st.cur == nic_pkg::LVL3 && !st.trapPend && !cpuEvt.trapExec && !st.trapActive
        |=> st.state == nic_pkg::NIC_RUN)
        else $error("maskable taken at level 3");
    interrupt_return_instruction_restore_a: assert property (st.state == nic_pkg::NIC_RUN && cpuEvt.iretExec &&
        !cpuEvt.trapExec |=> st.cur == {$past(cpuRegs.cc[5]), $past(cpuRegs.cc[3])})
        else $error("return did not restore level");
    enable_instr_a: assert property (st.state == nic_pkg::NIC_RUN && cpuEvt.rimExec &&
        !cpuEvt.trapExec |=> st.cur == nic_pkg::LVL0 ##1 condCode[5] && !condCode[3])
        else $error("enable instruction level wrong");
    lvl0_write_a: assert property (vprAcc.write && vprAcc.index == 2'h0 &&
        vprAcc.data[1:0] == nic_pkg::LVL0 |=> st.vpr[0] == $past(st.vpr[0]))
        else $error("level 0 write was stored");
    halt_wake_a: assert property ($fell(st.halted) && st.selKind == nic_pkg::KIND_MASK |->
        haltWakeMask[st.selVec])
        else $error("halt left by non-wake source");

    trap_cov: cover property (st.selKind == nic_pkg::KIND_TRAP && entry.fetchStart);
    tli_cov: cover property (st.selKind == nic_pkg::KIND_TLI && entry.fetchStart);
    mask_cov: cover property (st.selKind == nic_pkg::KIND_MASK && entry.fetchStart);
    halt_cov: cover property ($fell(st.halted));
    wait_cov: cover property ($fell(st.waiting));
endmodule

// ===== nic_cpu_model.sv
/*
 * CPU core model facing the controller: stacks pushed bytes, pops them on return.
 * Assumes cmd is driven by non-blocking assignment on the rising edge.
 */
`timescale 1ns/1ps
module nic_cpu_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // controller side
    input wire nic_pkg::nic_entry_t entry,
    input wire logic [7:0] condCode,
    output nic_pkg::nic_cpu_evt_t cpuEvt,
    output nic_pkg::nic_cpu_regs_t cpuRegs,
    // instruction pulses from the bench, never a trap inside the top-level handler
    input wire nic_pkg::nic_cpu_evt_t cmd
);
    logic [7:0] frame [$];
    initial cpuEvt = '0;
    initial cpuRegs = {16'h1234, 8'h56, 8'h78, 8'h00};
    always @(posedge core_clk) begin
        cpuEvt <= cmd;
        // one-cycle instructions, so each unstalled cycle is a boundary
        cpuEvt.instrEnd <= rst_n && !entry.busy;
        cpuRegs.cc <= condCode;
        if (entry.pushStrobe) frame.push_back(entry.pushData);
        if (entry.pcLoad) cpuRegs.pc <= entry.pcValue;
        // a return pops the whole frame; its last byte is the condition code
        if (cmd.iretExec && frame.size() >= 5) begin
            cpuRegs.cc <= frame[$];
            frame = frame[0:$-5];
        end
    end
endmodule

// ===== nic_ctrl_tb.sv
/*
 * Self-checking bench: priority writes, level instructions, arbitration,
 * nesting, trap and top-level, edge inputs, halt and wait wake-up.
 * Assumes the CPU model stacks and pops frames on behalf of the core.
 */
`timescale 1ns/1ps
module nic_ctrl_tb;
    logic core_clk;
    logic rst_n = 1'b0;
    logic tliPin = 1'b0;
    nic_pkg::nic_cpu_evt_t cpuEvt;
    nic_pkg::nic_cpu_evt_t cmd = '0;
    nic_pkg::nic_cpu_regs_t cpuRegs;
    nic_pkg::nic_entry_t entry;
    nic_pkg::nic_vpr_acc_t vprAcc = '0;
    logic [7:0] condCode, vprRdData;
    logic haltMode, waitMode;
    logic [15:0] extPin = '0;
    logic [13:1] flag = 13'h0200;
    logic [13:1] enable = 13'h1DFF;
    logic [13:1] flagClr = '0;
    logic [7:0] pushExp [5] = '{8'hFE, 8'hFF, 8'h56, 8'h78, 8'hE0};
    int errCount = 0;
    int checksDone = 0;
    int cycles = 0;

    nic_ctrl u_nic_ctrl (.core_clk(core_clk), .rst_n(rst_n), .clkEn(1'b1), .cpuEvt(cpuEvt),
        .cpuRegs(cpuRegs), .entry(entry), .condCode(condCode), .haltMode(haltMode),
        .waitMode(waitMode), .vprAcc(vprAcc), .vprRdData(vprRdData), .tliPin(tliPin),
        .tliRise(1'b1), .extPin(extPin), .extPinSelect(16'h0003), .extSenseRise(4'hF),
        .periphFlag(flag), .periphEnable(enable), .flagClear(flagClr),
        .haltWakeMask(13'h1FFE));
    nic_cpu_model u_nic_cpu_model (.core_clk(core_clk), .rst_n(rst_n), .entry(entry),
        .condCode(condCode), .cpuEvt(cpuEvt), .cpuRegs(cpuRegs), .cmd(cmd));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic giveVerdict();
        if (errCount == 0 && checksDone > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
        checksDone++;
        if (got !== exp) begin
            errCount++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // level bits sampled mid-cycle, then back on the driving edge
    task automatic lvl(input logic [1:0] lv);
        @(negedge core_clk);
        chk({condCode[5], condCode[3]}, lv, "level");
        @(posedge core_clk);
    endtask

    task automatic op(input nic_pkg::nic_cpu_evt_t c);
        cmd <= c;
        @(posedge core_clk);
        cmd <= '0;
        repeat (2) @(posedge core_clk);
    endtask

    task automatic vprWr(input logic [1:0] idx, input logic [7:0] d);
        vprAcc <= '{1'b1, idx, d};
        @(posedge core_clk);
        vprAcc.write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic clr(input logic [13:1] m);
        flag <= flag & ~m;
        flagClr <= m;
        @(posedge core_clk);
        flagClr <= '0;
        @(posedge core_clk);
    endtask

    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge core_clk);
            chk(entry.busy, 1'b0, "unexpected entry");
        end
        @(posedge core_clk);
    endtask

    task automatic expectEntry(input logic [15:0] addr, input logic [1:0] lv);
        int n;
        n = 0;
        @(negedge core_clk);
        while (entry.pcLoad !== 1'b1 && n < 40) begin
            @(negedge core_clk);
            n++;
        end
        chk({entry.pcLoad, entry.pcValue}, {1'b1, addr}, "vector");
        lvl(lv);
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errCount++;
            giveVerdict();
        end
    end

    initial begin
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        chk(condCode, 8'hE8, "reset cc");
        @(posedge core_clk);
        rst_n <= 1'b1;
        expectEntry(16'hFFFE, 2'b11);
        chk(u_nic_cpu_model.frame.size(), 17'h0, "reset stack");
        vprWr(2'h0, 8'hCF);
        vprWr(2'h0, 8'h64);
        lvl(2'b11);
        chk(vprRdData, 8'h44, "prio reg 0");
        vprWr(2'h3, 8'h00);
        lvl(2'b11);
        chk(vprRdData, 8'hF0, "prio reg 3");
        vprWr(2'h1, 8'h1F);
        vprWr(2'h2, 8'hD0);
        op(7'h08);
        lvl(2'b10);
        op(7'h04);
        lvl(2'b11);
        flag[7:6] <= 2'b11;
        quiet(20);
        op(7'h08);
        expectEntry(16'hFFEC, 2'b00);
        foreach (pushExp[i]) chk(u_nic_cpu_model.frame[i], pushExp[i], "push");
        clr(13'h0040);
        op(7'h10);
        expectEntry(16'hFFEE, 2'b01);
        clr(13'h0020);
        op(7'h10);
        lvl(2'b10);
        quiet(20);
        flag[9:8] <= 2'b11;
        expectEntry(16'hFFEA, 2'b00);
        clr(13'h0180);
        op(7'h10);
        quiet(20);
        op(7'h20);
        expectEntry(16'hFFFC, 2'b11);
        tliPin <= 1'b1;
        expectEntry(16'hFFFA, 2'b11);
        op(7'h10);
        op(7'h10);
        lvl(2'b10);
        tliPin <= 1'b0;
        extPin[1] <= 1'b1;
        expectEntry(16'hFFF6, 2'b00);
        op(7'h10);
        quiet(20);
        op(7'h02);
        chk(haltMode, 1'b1, "halt");
        flag[1] <= 1'b1;
        quiet(20);
        flag[6] <= 1'b1;
        expectEntry(16'hFFEE, 2'b01);
        clr(13'h0020);
        op(7'h10);
        expectEntry(16'hFFF8, 2'b01);
        clr(13'h0001);
        op(7'h10);
        op(7'h01);
        chk(waitMode, 1'b1, "wait");
        flag[1] <= 1'b1;
        expectEntry(16'hFFF8, 2'b01);
        giveVerdict();
    end
endmodule
